// file: hw/lft_ctrl.sv
// Purpose: Panel control register and frame timing for a segment panel driver
// Assumes: APB slave; panel clocks arrive asynchronously and are much slower than pclk
// Notes:   Panel base clock is counted as edges of the selected source
//
// Summary of operation
// - Disabled: pins off, clocks stopped, module idle
// - Enabled: drive only pins whose enable set
// - Backplane phases follow the selected duty
// - Enable also turns on selected bias generator
// - Source bit picks oscillator or alternate clock
// - Frame = clock/((duty+1)*8*(4+prescaler)*Y)
// - Y is 2,2,3,3,4,5,8,16 per duty
// - Duty field selects field plus one backplanes
// - Duty resets to four backplanes
//
// The register addresses and the APB register port were decided locally.
`timescale 1ns/10ps
`default_nettype none
module lft_ctrl
  import lft_pkg::*;
#(
  parameter int NPINS = 8
)
(
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [7:0]       paddr,
  input  wire logic [31:0]      pwdata,
  output var  logic [31:0]      prdata,
  output var  logic             pready,
  output var  logic             pslverr,
  input  wire logic             oscillator_output,
  input  wire logic             alt_clock,
  input  wire logic             bias_pump_select,
  output var  logic [NPINS-1:0] pin_drive_en,
  output var  logic [NPINS-1:0] backplane_active,
  output var  logic [2:0]       backplane_phase,
  output var  logic             frame_start,
  output var  logic             pump_enable,
  output var  logic             resistor_enable
);
  logic [7:0]       panel_control_zero;
  logic [NPINS-1:0] pin_enable_bits;
  logic [NPINS-1:0] backplane_select;
  logic [7:0]       sub_cnt;
  logic [4:0]       y_cnt;
  logic [2:0]       phase;
  logic             en_d;
  logic             osc_rise;
  logic             alt_rise;

  // Field views of the control register
  wire       panel_driver_enable = panel_control_zero[LFT_EN_BIT];
  wire       clk_src             = panel_control_zero[LFT_SRC_BIT];
  wire [2:0] frame_prescaler     = panel_control_zero[LFT_PRE_LSB +: 3];
  wire [2:0] duty                = panel_control_zero[LFT_DUTY_LSB +: 3];

  // APB decode; zero-wait answer, unmapped addresses error out
  wire acc      = psel && penable;
  wire hit_ctrl = paddr == LFT_CTRL_OFS;
  wire hit_pin  = paddr == LFT_PINEN_OFS;
  wire hit_bsel = paddr == LFT_BPSEL_OFS;
  wire hit_st   = paddr == LFT_STATUS_OFS;
  wire mapped   = hit_ctrl || hit_pin || hit_bsel || hit_st;
  wire wr       = acc && pwrite && mapped;
  wire [7:0] status_byte = {4'h0, (phase == 3'h0), phase};
  wire [31:0] next_prdata =
    hit_ctrl ? {24'h0, panel_control_zero} :
    hit_pin  ? {{(32-NPINS){1'b0}}, pin_enable_bits} :
    hit_bsel ? {{(32-NPINS){1'b0}}, backplane_select} :
    hit_st   ? {24'h0, status_byte} : 32'h0;

  // Clock source choice; edges of the chosen source advance the divider
  wire base_tick = clk_src ? alt_rise : osc_rise;

  // Divider terms; one sub-period of 8*(4+prescaler) base clocks
  wire [7:0] sub_len = 8'(LFT_MUL_EIGHT * (LFT_PRE_BASE + int'(frame_prescaler)));
  wire [4:0] y_len   = LFT_Y_TABLE[{duty, 3'h0} +: 5];
  wire       sub_end = base_tick && (sub_cnt == sub_len - 8'h01);
  wire       y_end   = sub_end && (y_cnt == y_len - 5'h01);
  wire       restart = panel_driver_enable && !en_d;

  lft_sync u_osc_sync
  (
    .pclk    (pclk),
    .presetn (presetn),
    .din     (oscillator_output),
    .rise    (osc_rise)
  );

  lft_sync u_alt_sync
  (
    .pclk    (pclk),
    .presetn (presetn),
    .din     (alt_clock),
    .rise    (alt_rise)
  );

  // Register writes; field change while enabled is the software's burden
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      panel_control_zero <= LFT_CTRL_RST;
      pin_enable_bits    <= NPINS'(LFT_PINEN_RST);
      backplane_select   <= NPINS'(LFT_BPSEL_RST);
      prdata             <= 32'h0;
      pready             <= 1'b0;
      pslverr            <= 1'b0;
    end
    else
    begin
      if (wr && hit_ctrl)
        panel_control_zero <= pwdata[7:0];
      if (wr && hit_pin)
        pin_enable_bits <= pwdata[NPINS-1:0];
      if (wr && hit_bsel)
        backplane_select <= pwdata[NPINS-1:0];
      prdata  <= (psel && !penable && !pwrite) ? next_prdata : prdata;
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
    end
  end

  // Frame divider: base ticks -> sub-period -> Y count -> backplane phase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      en_d    <= 1'b0;
      sub_cnt <= 8'h0;
      y_cnt   <= 5'h0;
      phase   <= 3'h0;
    end
    else
    begin
      en_d <= panel_driver_enable;
      if (!panel_driver_enable || restart)
      begin
        sub_cnt <= 8'h0;
        y_cnt   <= 5'h0;
        phase   <= 3'h0;
      end
      else if (base_tick)
      begin
        sub_cnt <= sub_end ? 8'h0 : sub_cnt + 8'h01;
        if (sub_end)
          y_cnt <= y_end ? 5'h0 : y_cnt + 5'h01;
        if (y_end)
          phase <= (phase == duty) ? 3'h0 : phase + 3'h1;
      end
    end
  end

  // Pin and bias outputs, all registered
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_drive_en     <= '0;
      backplane_active <= '0;
      backplane_phase  <= 3'h0;
      frame_start      <= 1'b0;
      pump_enable      <= 1'b0;
      resistor_enable  <= 1'b0;
    end
    else
    begin
      pin_drive_en     <= panel_driver_enable ? pin_enable_bits : '0;
      backplane_active <= panel_driver_enable ? (pin_enable_bits & backplane_select) : '0;
      backplane_phase  <= phase;
      frame_start      <= (y_end && phase == duty && panel_driver_enable) || restart;
      pump_enable      <= panel_driver_enable && bias_pump_select;
      resistor_enable  <= panel_driver_enable && !bias_pump_select;
    end
  end

  // Checks; divider ones rely on software keeping the fields still while enabled
  a_disable_pins: assert property (@(posedge pclk) disable iff (!presetn)
    !panel_driver_enable |=> pin_drive_en == '0 && !pump_enable && !resistor_enable)
    else $error("pins driven while disabled");
  a_pin_mask: assert property (@(posedge pclk) disable iff (!presetn)
    panel_driver_enable |=> (pin_drive_en & ~$past(pin_enable_bits)) == '0)
    else $error("unenabled pin driven");
  a_phase_bound: assert property (@(posedge pclk) disable iff (!presetn)
    phase <= duty)
    else $error("phase beyond duty");
  a_phase_step: assert property (@(posedge pclk) disable iff (!presetn)
    panel_driver_enable && !restart && !y_end |=> $stable(phase))
    else $error("phase moved between phase ends");
  a_bias_on: assert property (@(posedge pclk) disable iff (!presetn)
    panel_driver_enable |=> (pump_enable ^ resistor_enable))
    else $error("bias not enabled");
  a_src_select: assert property (@(posedge pclk) disable iff (!presetn)
    panel_driver_enable && !restart && (clk_src ? !alt_rise : !osc_rise) |=> $stable(sub_cnt))
    else $error("unselected source advanced divider");
  a_sub_wrap: assert property (@(posedge pclk) disable iff (!presetn)
    sub_cnt < sub_len || !panel_driver_enable)
    else $error("sub counter overflow");
  a_y_factor: assert property (@(posedge pclk) disable iff (!presetn)
    y_len == ((duty == 3'h7) ? 5'h10 :
              (duty == 3'h6) ? 5'h08 :
              (duty == 3'h5) ? 5'h05 :
              (duty == 3'h4) ? 5'h04 :
              (duty >= 3'h2) ? 5'h03 : 5'h02))
    else $error("factor table wrong");
  a_phase_wrap: assert property (@(posedge pclk) disable iff (!presetn)
    panel_driver_enable && !restart && y_end && phase == duty |=> phase == 3'h0)
    else $error("phase did not wrap at duty");
  a_restart_frame: assert property (@(posedge pclk) disable iff (!presetn)
    restart |=> phase == 3'h0 && sub_cnt == 8'h0 && y_cnt == 5'h0)
    else $error("no restart on enable");
  a_reset_duty: assert property (@(posedge pclk)
    $rose(presetn) |-> duty == 3'h3)
    else $error("duty reset value wrong");

  // Scenario covers
  c_enable: cover property (@(posedge pclk) disable iff (!presetn) restart);
  c_frame: cover property (@(posedge pclk) disable iff (!presetn) frame_start && !restart);
  c_phase_wrap: cover property (@(posedge pclk) disable iff (!presetn) y_end && phase == duty);
  c_alt_source: cover property (@(posedge pclk) disable iff (!presetn) base_tick && clk_src);
endmodule
`default_nettype wire

// file: hw/lft_pkg.sv
// Purpose: Constants for the panel frame timing control block
// Assumes: APB slave, 32-bit data, byte addresses
// Notes:   Offsets of the control and pin registers are chosen here
package lft_pkg;

  // Register offsets
  localparam logic [7:0] LFT_CTRL_OFS   = 8'h00;
  localparam logic [7:0] LFT_PINEN_OFS  = 8'h04;
  localparam logic [7:0] LFT_BPSEL_OFS  = 8'h08;
  localparam logic [7:0] LFT_STATUS_OFS = 8'h0C;

  // Control field positions
  localparam int LFT_EN_BIT   = 7;
  localparam int LFT_SRC_BIT  = 6;
  localparam int LFT_PRE_LSB  = 3;
  localparam int LFT_DUTY_LSB = 0;

  // Reset values
  localparam logic [7:0] LFT_CTRL_RST  = 8'h03;
  localparam logic [7:0] LFT_PINEN_RST = 8'h00;
  localparam logic [7:0] LFT_BPSEL_RST = 8'h00;

  // Frame equation constants
  localparam int LFT_MUL_EIGHT = 8;
  localparam int LFT_PRE_BASE  = 4;

  // Duty-dependent factor, one byte per duty code, code 0 in the lowest byte
  localparam logic [63:0] LFT_Y_TABLE = 64'h1008_0504_0303_0202;

endpackage

// file: hw/lft_sync.sv
// Purpose: Three-stage synchroniser with agreement filter for one clock input
// Assumes: Input is asynchronous to pclk
// Notes:   First stage feeds only the second stage
`timescale 1ns/10ps
`default_nettype none
module lft_sync
(
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic din,
  output var  logic rise
);
  logic s1;
  logic s2;
  logic s3;
  logic level;

  // Shift chain; a change counts once stages two and three agree
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s1    <= 1'b0;
      s2    <= 1'b0;
      s3    <= 1'b0;
      level <= 1'b0;
      rise  <= 1'b0;
    end
    else
    begin
      s1    <= din;
      s2    <= s1;
      s3    <= s2;
      if (s2 == s3)
        level <= s3;
      rise  <= (s2 == s3) && s3 && !level;
    end
  end
endmodule
`default_nettype wire

// file: test/lft_ctrl_test.sv
// Purpose: Self-checking bench for the panel frame timing control block
// Assumes: Fast source clocks stand in for the slow panel clock
// Notes:   Frame lengths are measured in pclk cycles between wraps
`timescale 1ns/10ps
`default_nettype none
module lft_ctrl_test;
  import lft_pkg::*;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00, pin_drive_en, backplane_active;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        osc = 1'b0, alt = 1'b0, bias = 1'b0, err, pready, pslverr;
  logic        frame_start, pump_enable, resistor_enable;
  logic [2:0]  backplane_phase, last_top;
  logic [3:0]  div = 4'h0;
  int          fails = 0, n_checks = 0, n;
  int          ytab [8] = '{2, 2, 3, 3, 4, 5, 8, 16};
  lft_ctrl i_lft_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .oscillator_output(osc), .alt_clock(alt), .bias_pump_select(bias),
    .pin_drive_en(pin_drive_en), .backplane_active(backplane_active),
    .backplane_phase(backplane_phase), .frame_start(frame_start),
    .pump_enable(pump_enable), .resistor_enable(resistor_enable));
  lft_panel i_lft_panel (.pclk(pclk), .presetn(presetn), .backplane_phase(backplane_phase),
    .frame_start(frame_start), .last_top(last_top));
  always #5 pclk = ~pclk;
  // Oscillator period 8 pclk, alternate 16 pclk, so a source mix-up shows
  always @(posedge pclk)
  begin
    div <= div + 4'h1;
    osc <= div[2];
    alt <= div[3];
  end
  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++)
    begin
      @(posedge pclk);
      if (pready === 1'b1)
        break;
    end
    if (i == 20)
    begin
      fails++;
      complete_run();
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  // Cycles up to the next frame pulse, bounded
  task automatic wait_fs(output int c);
    for (c = 1; c < 40000; c++)
    begin
      @(posedge pclk);
      if (frame_start === 1'b1)
        return;
    end
    fails++;
    complete_run();
  endtask
  task automatic t_reset();
    apb(1'b0, LFT_CTRL_OFS, 32'h0);
    check("ctrl", rd, {24'h0, LFT_CTRL_RST});
    check("pins", {pin_drive_en, pump_enable, resistor_enable}, 32'h0);
    apb(1'b0, 8'h10, 32'h0);
    check("unmapped", {31'h0, err}, 32'h1);
    check("unmapped_rd", rd, 32'h0);
  endtask
  task automatic t_frame(input logic src, input logic bsel, input logic [2:0] pre,
                         input logic [2:0] duty);
    int exp;
    exp = (duty + 1) * 8 * (4 + pre) * ytab[duty] * (src ? 16 : 8);
    bias <= bsel;
    apb(1'b1, LFT_PINEN_OFS, 32'hF0);
    apb(1'b1, LFT_BPSEL_OFS, 32'h30);
    apb(1'b1, LFT_CTRL_OFS, {24'h0, 1'b1, src, pre, duty});
    wait_fs(n);
    check("restart", n <= 10, 32'h1);
    wait_fs(n);
    wait_fs(n);
    check("frame", n, exp);
    check("phases", last_top, duty);
    check("drive", pin_drive_en, 32'hF0);
    check("backplane", backplane_active, 32'h30);
    check("bias", {pump_enable, resistor_enable}, {bsel, ~bsel});
    // Disable before any field changes
    apb(1'b1, LFT_CTRL_OFS, {24'h0, 1'b0, src, pre, duty});
    repeat (3) @(posedge pclk);
    check("off", {pin_drive_en, backplane_active, pump_enable, resistor_enable}, 32'h0);
    check("phase0", backplane_phase, 32'h0);
    apb(1'b0, LFT_STATUS_OFS, 32'h0);
    check("status", rd, 32'h08);
  endtask
  initial
  begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_frame(1'b0, 1'b1, 3'h0, 3'h0);
    t_frame(1'b1, 1'b0, 3'h0, 3'h0);
    t_frame(1'b0, 1'b0, 3'h1, 3'h3);
    t_frame(1'b0, 1'b1, 3'h0, 3'h6);
    complete_run();
  end
endmodule
`default_nettype wire

// file: test/lft_panel.sv
// Purpose: Panel glass model that tracks the backplane phases of each frame
// Assumes: Phase and frame pulse come from the driver on pclk
// Notes:   Reports the highest phase seen in the last whole frame
`timescale 1ns/10ps
`default_nettype none
module lft_panel
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [2:0] backplane_phase,
  input  wire logic       frame_start,
  output var  logic [2:0] last_top
);
  logic [2:0] top;
  // Latch the top phase at each wrap, so a short frame shows up
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      top      <= 3'h0;
      last_top <= 3'h0;
    end
    else if (frame_start)
    begin
      last_top <= top;
      top      <= 3'h0;
    end
    else if (backplane_phase > top)
      top <= backplane_phase;
  end
endmodule
`default_nettype wire
